// file: rtl/pmc_pkg.sv
// Constants, register map, field layout and state types of the power mode controller.
// Assumes an APB master on the same clock as the controller.
package pmc_pkg;

  localparam int         ADDR_W       = 4;
  localparam logic [3:0] OFS_CTRL_ONE = 4'h0;
  localparam logic [3:0] OFS_CTRL_TWO = 4'h4;
  localparam logic [3:0] OFS_MSTBY    = 4'h8;
  localparam logic [3:0] OFS_STATUS   = 4'hC;

  // system_control_one fields
  localparam int C1_STBY_BIT = 7;
  localparam int C1_WAIT_LSB = 4;
  localparam int WAIT_W      = 3;
  // system_control_two fields
  localparam int C2_ADIV_LSB = 5;
  localparam int ADIV_W      = 3;
  localparam int C2_DT_BIT   = 4;
  localparam int C2_LS_BIT   = 3;
  localparam int C2_SDIV_LSB = 0;
  localparam int SDIV_W      = 2;
  // status fields
  localparam int ST_MODE_LSB = 0;
  localparam int MODE_W      = 3;
  localparam int ST_NOWK_BIT = 4;
  localparam int ST_OSC_BIT  = 5;

  // SLEEP execution states plus internal processing states
  localparam int DT_PRE_STATES = 3;
  localparam int DIV_CNT_W     = 7;

  typedef enum logic [2:0] {
    M_ACT  = 3'h0,
    M_SLP  = 3'h1,
    M_SSLP = 3'h2,
    M_STBY = 3'h3,
    M_SACT = 3'h4,
    M_DTSW = 3'h5,
    M_OSCW = 3'h6,
    M_RSTH = 3'h7
  } pmc_mode_t;

  typedef struct packed {
    logic              stby_sel;
    logic [WAIT_W-1:0] wait_select;
    logic [ADIV_W-1:0] active_divider;
    logic              direct_transition_select;
    logic              low_speed_select;
    logic [SDIV_W-1:0] sub_divider;
  } pmc_cfg_t;

  localparam pmc_cfg_t CFG_RST = '0;

  // Subactive divider code to power-of-two shift: 00 gives /8, 01 /4, else /2
  function automatic logic [ADIV_W-1:0] sub_shift(input logic [SDIV_W-1:0] code);
    case (code)
      2'h0:    sub_shift = 3'h3;
      2'h1:    sub_shift = 3'h2;
      default: sub_shift = 3'h1;
    endcase
  endfunction : sub_shift

endpackage : pmc_pkg

// file: rtl/pmc_sync.sv
// Two-flop synchroniser for level inputs from outside the clock domain.
// Assumes inputs are slow levels; no pulse is shorter than two clocks.
`timescale 1ns/10ps
module pmc_sync #(
  parameter int         W       = 1,
  parameter logic [0:0] RST_VAL = 1'h0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pmc_sync_st_t;

  pmc_sync_st_t s_ff;
  pmc_sync_st_t nxt_s;

  always_comb begin
    nxt_s.s1 = d;
    nxt_s.s2 = s_ff.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= {(2 * W){RST_VAL}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.s2;

endmodule : pmc_sync

// file: rtl/pmc_div.sv
// Power-of-two tick divider: one output tick per 2**shift source ticks.
// The shift is sampled only at a period boundary, so no short period occurs.
`timescale 1ns/10ps
module pmc_div #(
  parameter int CNT_W = pmc_pkg::DIV_CNT_W
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Source and ratio
  input  wire logic       src_tick,
  input  wire logic [2:0] shift,
  // Divided tick
  output logic            tick
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } pmc_div_st_t;

  pmc_div_st_t s_ff;
  pmc_div_st_t nxt_s;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.tick = 1'b0;
    if (src_tick) begin
      if (s_ff.cnt == '0) begin
        // Reload only here keeps every period whole
        nxt_s.cnt  = CNT_W'((1 << shift) - 1);
        nxt_s.tick = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;

endmodule : pmc_div

// file: rtl/pmc_top.sv
// Power mode controller: mode sequencing, clock enables, module standby, APB registers.
// Assumes CPU, interrupt logic and APB master share SYS_CLK; pins are asynchronous.
`timescale 1ns/10ps
module pmc_top #(
  parameter int NMOD      = 8,
  parameter int NIRQ      = 8,
  parameter int WAIT_UNIT = 64
) (
  // Clock and reset
  input  wire logic                        SYS_CLK,
  input  wire logic                        RST,
  // APB slave
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [pmc_pkg::ADDR_W-1:0]  PADDR,
  input  wire logic [31:0]                 PWDATA,
  output logic      [31:0]                 PRDATA,
  output logic                             PREADY,
  output logic                             PSLVERR,
  // Pins
  input  wire logic                        RESET_PIN_N,
  input  wire logic                        WATCH_CLK,
  // CPU and interrupt logic
  input  wire logic                        SLEEP_EXEC,
  input  wire logic                        CCR_I_MASK,
  input  wire logic [NIRQ-1:0]             IRQ_REQ,
  input  wire logic [NIRQ-1:0]             IRQ_ENA,
  input  wire logic                        DT_IRQ_ENA,
  // Clock enables
  output logic                             CPU_CLK_EN,
  output logic      [NMOD-1:0]             PERI_CLK_EN,
  output logic                             TIMER_A_CLK_EN,
  output logic                             OSC_ENABLE,
  // Status to the chip
  output logic                             CPU_RESET,
  output logic                             CPU_RETAIN,
  output logic                             IO_HOLD,
  output logic                             IO_HIZ,
  output logic                             EXC_START,
  output logic                             DT_EXC_START,
  output logic      [2:0]                  MODE
);
  localparam int CNT_W = $clog2(WAIT_UNIT) + 8;

  typedef struct packed {
    pmc_pkg::pmc_cfg_t         cfg;
    logic [pmc_pkg::ADIV_W-1:0] act_div;
    logic [pmc_pkg::SDIV_W-1:0] act_sub;
    logic [NMOD-1:0]           mstby;
    pmc_pkg::pmc_mode_t        mode;
    logic                      wait_to_sub;
    logic                      dt_pend;
    logic                      no_wake;
    logic [CNT_W-1:0]          cnt;
    logic                      watch_q;
    logic                      cpu_en;
    logic [NMOD-1:0]           peri_en;
    logic                      ta_en;
    logic                      osc_en;
    logic                      cpu_rst;
    logic                      retain;
    logic                      io_hold;
    logic                      io_hiz;
    logic                      exc;
    logic                      dt_exc;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
  } pmc_top_st_t;

  pmc_top_st_t s_ff;
  pmc_top_st_t nxt_s;

  logic             rpin_s;
  logic             watch_s;
  logic             sys_tick;
  logic             sub_tick;
  logic             watch_edge;
  logic             wake;
  logic             acc;
  logic             old_tick;
  logic             dt_ok;
  logic             cpu_base;
  logic             peri_base;
  logic [CNT_W-1:0] wait_lim;
  logic [CNT_W-1:0] dt_last;

  pmc_sync #(
    .W       (1),
    .RST_VAL (1'h1)
  ) u_rpin_sync (
    .clk (SYS_CLK),
    .rst (RST),
    .d   (RESET_PIN_N),
    .q   (rpin_s)
  );

  pmc_sync #(
    .W       (1),
    .RST_VAL (1'h0)
  ) u_watch_sync (
    .clk (SYS_CLK),
    .rst (RST),
    .d   (WATCH_CLK),
    .q   (watch_s)
  );

  // System clock runs only while the oscillator is enabled
  pmc_div u_sys_div (
    .clk      (SYS_CLK),
    .rst      (RST),
    .src_tick (s_ff.osc_en),
    .shift    (s_ff.act_div),
    .tick     (sys_tick)
  );

  pmc_div u_sub_div (
    .clk      (SYS_CLK),
    .rst      (RST),
    .src_tick (watch_edge),
    .shift    (pmc_pkg::sub_shift(s_ff.act_sub)),
    .tick     (sub_tick)
  );

  assign watch_edge = watch_s & ~s_ff.watch_q;
  assign acc        = PSEL & PENABLE;
  assign wait_lim   = CNT_W'((WAIT_UNIT << s_ff.cfg.wait_select) - 1);
  assign dt_last    = CNT_W'(pmc_pkg::DT_PRE_STATES - 1);
  // Old clock during a direct transition is the mode being left
  assign old_tick   = s_ff.wait_to_sub ? sys_tick : sub_tick;

  always_comb begin
    nxt_s         = s_ff;
    nxt_s.exc     = 1'b0;
    nxt_s.dt_exc  = 1'b0;
    nxt_s.watch_q = watch_s;
    nxt_s.pready  = acc & ~s_ff.pready;
    nxt_s.pslverr = 1'b0;
    nxt_s.prdata  = '0;
    wake          = (|(IRQ_REQ & IRQ_ENA)) & ~CCR_I_MASK;
    dt_ok         = s_ff.cfg.direct_transition_select & DT_IRQ_ENA & ~CCR_I_MASK;

    case (s_ff.mode)
      pmc_pkg::M_ACT, pmc_pkg::M_SACT: begin
        if (SLEEP_EXEC) begin
          // Masked attempt can only be left by the reset pin
          nxt_s.no_wake = s_ff.cfg.direct_transition_select & CCR_I_MASK;
          if (dt_ok && (s_ff.cfg.low_speed_select == (s_ff.mode == pmc_pkg::M_SACT))) begin
            // Same-mode direct transition only changes frequency
            nxt_s.act_div = s_ff.cfg.active_divider;
            nxt_s.act_sub = s_ff.cfg.sub_divider;
            nxt_s.dt_exc  = 1'b1;
          end else if (dt_ok) begin
            nxt_s.mode        = pmc_pkg::M_DTSW;
            nxt_s.wait_to_sub = s_ff.cfg.low_speed_select;
            nxt_s.cnt         = '0;
          end else begin
            nxt_s.act_div = s_ff.cfg.active_divider;
            nxt_s.act_sub = s_ff.cfg.sub_divider;
            if (!s_ff.cfg.direct_transition_select && s_ff.cfg.stby_sel) begin
              nxt_s.mode = pmc_pkg::M_STBY;
            end else if (s_ff.cfg.low_speed_select) begin
              nxt_s.mode = pmc_pkg::M_SSLP;
            end else begin
              nxt_s.mode = pmc_pkg::M_SLP;
            end
          end
        end
      end
      pmc_pkg::M_DTSW: begin
        if (old_tick) begin
          if (s_ff.cnt == dt_last) begin
            // Divider swap at the switch point, not at SLEEP
            nxt_s.act_div = s_ff.cfg.active_divider;
            nxt_s.act_sub = s_ff.cfg.sub_divider;
            nxt_s.cnt     = '0;
            if (s_ff.wait_to_sub) begin
              nxt_s.mode   = pmc_pkg::M_SACT;
              nxt_s.dt_exc = 1'b1;
            end else begin
              nxt_s.mode    = pmc_pkg::M_OSCW;
              nxt_s.dt_pend = 1'b1;
            end
          end else begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
          end
        end
      end
      pmc_pkg::M_OSCW: begin
        // Wait counted in ticks of the new system clock
        if (sys_tick) begin
          if (s_ff.cnt == wait_lim) begin
            nxt_s.mode    = s_ff.wait_to_sub ? pmc_pkg::M_SACT : pmc_pkg::M_ACT;
            nxt_s.exc     = ~s_ff.dt_pend;
            nxt_s.dt_exc  = s_ff.dt_pend;
            nxt_s.dt_pend = 1'b0;
          end else begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
          end
        end
      end
      pmc_pkg::M_SLP: begin
        if (wake && !s_ff.no_wake) begin
          nxt_s.mode = s_ff.cfg.low_speed_select ? pmc_pkg::M_SACT : pmc_pkg::M_ACT;
          nxt_s.exc  = 1'b1;
        end
      end
      pmc_pkg::M_SSLP: begin
        if (wake && !s_ff.no_wake) begin
          if (s_ff.cfg.low_speed_select) begin
            nxt_s.mode = pmc_pkg::M_SACT;
            nxt_s.exc  = 1'b1;
          end else begin
            // Oscillator was stopped, so active needs the start-up wait
            nxt_s.mode        = pmc_pkg::M_OSCW;
            nxt_s.wait_to_sub = 1'b0;
            nxt_s.dt_pend     = 1'b0;
            nxt_s.cnt         = '0;
          end
        end
      end
      pmc_pkg::M_STBY: begin
        if (wake && !s_ff.no_wake) begin
          nxt_s.mode        = pmc_pkg::M_OSCW;
          nxt_s.wait_to_sub = s_ff.cfg.low_speed_select;
          nxt_s.dt_pend     = 1'b0;
          nxt_s.cnt         = '0;
        end
      end
      pmc_pkg::M_RSTH: begin
        if (rpin_s) begin
          nxt_s.mode = pmc_pkg::M_ACT;
        end
      end
      default: begin
        nxt_s.mode = pmc_pkg::M_ACT;
      end
    endcase

    // Decode in the first access cycle, answer one cycle later with PREADY
    if (acc && !s_ff.pready) begin
      case (PADDR)
        pmc_pkg::OFS_CTRL_ONE: begin
          nxt_s.prdata[pmc_pkg::C1_STBY_BIT] = s_ff.cfg.stby_sel;
          nxt_s.prdata[pmc_pkg::C1_WAIT_LSB +: pmc_pkg::WAIT_W] = s_ff.cfg.wait_select;
        end
        pmc_pkg::OFS_CTRL_TWO: begin
          nxt_s.prdata[pmc_pkg::C2_ADIV_LSB +: pmc_pkg::ADIV_W] = s_ff.cfg.active_divider;
          nxt_s.prdata[pmc_pkg::C2_DT_BIT] = s_ff.cfg.direct_transition_select;
          nxt_s.prdata[pmc_pkg::C2_LS_BIT] = s_ff.cfg.low_speed_select;
          nxt_s.prdata[pmc_pkg::C2_SDIV_LSB +: pmc_pkg::SDIV_W] = s_ff.cfg.sub_divider;
        end
        pmc_pkg::OFS_MSTBY: begin
          nxt_s.prdata[NMOD-1:0] = s_ff.mstby;
        end
        pmc_pkg::OFS_STATUS: begin
          nxt_s.prdata[pmc_pkg::ST_MODE_LSB +: pmc_pkg::MODE_W] = s_ff.mode;
          nxt_s.prdata[pmc_pkg::ST_NOWK_BIT] = s_ff.no_wake;
          nxt_s.prdata[pmc_pkg::ST_OSC_BIT]  = s_ff.osc_en;
        end
        default: begin
          nxt_s.pslverr = 1'b1;
        end
      endcase
    end

    if (acc && s_ff.pready && PWRITE) begin
      case (PADDR)
        pmc_pkg::OFS_CTRL_ONE: begin
          nxt_s.cfg.stby_sel    = PWDATA[pmc_pkg::C1_STBY_BIT];
          nxt_s.cfg.wait_select = PWDATA[pmc_pkg::C1_WAIT_LSB +: pmc_pkg::WAIT_W];
        end
        pmc_pkg::OFS_CTRL_TWO: begin
          nxt_s.cfg.active_divider = PWDATA[pmc_pkg::C2_ADIV_LSB +: pmc_pkg::ADIV_W];
          nxt_s.cfg.direct_transition_select = PWDATA[pmc_pkg::C2_DT_BIT];
          nxt_s.cfg.low_speed_select = PWDATA[pmc_pkg::C2_LS_BIT];
          nxt_s.cfg.sub_divider = PWDATA[pmc_pkg::C2_SDIV_LSB +: pmc_pkg::SDIV_W];
        end
        pmc_pkg::OFS_MSTBY: begin
          nxt_s.mstby = PWDATA[NMOD-1:0];
        end
        default: begin
        end
      endcase
    end

    // Reset pin wins over everything, in any mode
    if (!rpin_s) begin
      nxt_s.mode    = pmc_pkg::M_RSTH;
      nxt_s.cfg     = pmc_pkg::CFG_RST;
      nxt_s.act_div = '0;
      nxt_s.act_sub = '0;
      nxt_s.mstby   = '0;
      nxt_s.no_wake = 1'b0;
      nxt_s.dt_pend = 1'b0;
      nxt_s.exc     = 1'b0;
      nxt_s.dt_exc  = 1'b0;
    end

    cpu_base  = 1'b0;
    peri_base = 1'b0;
    case (nxt_s.mode)
      pmc_pkg::M_ACT: begin
        cpu_base  = sys_tick;
        peri_base = sys_tick;
      end
      pmc_pkg::M_SACT: begin
        cpu_base  = sub_tick;
        peri_base = sub_tick;
      end
      pmc_pkg::M_SLP: begin
        peri_base = sys_tick;
      end
      pmc_pkg::M_DTSW: begin
        cpu_base  = old_tick;
        peri_base = old_tick;
      end
      default: begin
      end
    endcase
    // Subsleep, standby and waits give no CPU or peripheral clock
    nxt_s.cpu_en  = cpu_base;
    nxt_s.peri_en = {NMOD{peri_base}} & ~nxt_s.mstby;
    nxt_s.ta_en   = watch_edge;
    nxt_s.osc_en  = (nxt_s.mode == pmc_pkg::M_ACT) || (nxt_s.mode == pmc_pkg::M_SLP) ||
                    (nxt_s.mode == pmc_pkg::M_OSCW) || (nxt_s.mode == pmc_pkg::M_RSTH) ||
                    ((nxt_s.mode == pmc_pkg::M_DTSW) && nxt_s.wait_to_sub);
    nxt_s.cpu_rst = (nxt_s.mode == pmc_pkg::M_RSTH);
    nxt_s.retain  = (nxt_s.mode == pmc_pkg::M_SLP) || (nxt_s.mode == pmc_pkg::M_SSLP) ||
                    (nxt_s.mode == pmc_pkg::M_STBY) || (nxt_s.mode == pmc_pkg::M_OSCW);
    nxt_s.io_hold = (nxt_s.mode == pmc_pkg::M_SSLP);
    nxt_s.io_hiz  = (nxt_s.mode == pmc_pkg::M_STBY);
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign PRDATA         = s_ff.prdata;
  assign PREADY         = s_ff.pready;
  assign PSLVERR        = s_ff.pslverr;
  assign CPU_CLK_EN     = s_ff.cpu_en;
  assign PERI_CLK_EN    = s_ff.peri_en;
  assign TIMER_A_CLK_EN = s_ff.ta_en;
  assign OSC_ENABLE     = s_ff.osc_en;
  assign CPU_RESET      = s_ff.cpu_rst;
  assign CPU_RETAIN     = s_ff.retain;
  assign IO_HOLD        = s_ff.io_hold;
  assign IO_HIZ         = s_ff.io_hiz;
  assign EXC_START      = s_ff.exc;
  assign DT_EXC_START   = s_ff.dt_exc;
  assign MODE           = s_ff.mode;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_subsleep_no_clk: assert property (
    (MODE == pmc_pkg::M_SSLP) |-> (!CPU_CLK_EN && (PERI_CLK_EN == '0))
  ) else $error("clock enable active in subsleep");

  a_timer_a_runs: assert property (
    watch_edge |=> TIMER_A_CLK_EN
  ) else $error("watch timer tick lost");

  a_retain_halts: assert property (
    CPU_RETAIN |-> !CPU_CLK_EN
  ) else $error("CPU clocked while retaining");

  a_io_hold_sub: assert property (
    (MODE == pmc_pkg::M_SSLP) |-> (IO_HOLD && !IO_HIZ)
  ) else $error("ports not held in subsleep");

  a_wake_exc: assert property (
    (s_ff.mode == pmc_pkg::M_SSLP && wake && !s_ff.no_wake && rpin_s &&
     s_ff.cfg.low_speed_select) |=> (EXC_START && MODE == pmc_pkg::M_SACT)
  ) else $error("subsleep wake did not start exception");

  a_masked_stay: assert property (
    (s_ff.mode == pmc_pkg::M_SSLP && CCR_I_MASK && rpin_s) |=> (MODE == pmc_pkg::M_SSLP)
  ) else $error("masked interrupt left subsleep");

  a_wake_to_osc: assert property (
    (s_ff.mode == pmc_pkg::M_SSLP && wake && !s_ff.no_wake && rpin_s &&
     !s_ff.cfg.low_speed_select) |=> (MODE == pmc_pkg::M_OSCW && OSC_ENABLE)
  ) else $error("subsleep wake to active skipped oscillator");

  a_rst_pin_hold: assert property (
    !rpin_s |=> (CPU_RESET && OSC_ENABLE && MODE == pmc_pkg::M_RSTH)
  ) else $error("reset pin did not hold CPU");

  a_div_latched: assert property (
    (!SLEEP_EXEC && s_ff.mode != pmc_pkg::M_DTSW && rpin_s) |=>
      ($stable(s_ff.act_div) && $stable(s_ff.act_sub))
  ) else $error("divider applied without SLEEP");

  a_dt_disabled: assert property (
    (SLEEP_EXEC && s_ff.mode == pmc_pkg::M_ACT && s_ff.cfg.direct_transition_select &&
     !DT_IRQ_ENA && rpin_s) |=> (MODE == pmc_pkg::M_SLP || MODE == pmc_pkg::M_SSLP)
  ) else $error("disabled direct transition not turned into sleep");

  a_dt_masked: assert property (
    (SLEEP_EXEC && s_ff.mode == pmc_pkg::M_SACT && s_ff.cfg.direct_transition_select &&
     CCR_I_MASK && rpin_s) |=> s_ff.no_wake ##1 (!EXC_START && !DT_EXC_START)
  ) else $error("masked direct transition wakeable");

  a_osc_wait_halt: assert property (
    (MODE == pmc_pkg::M_OSCW) |-> (!CPU_CLK_EN && !EXC_START)
  ) else $error("CPU ran during oscillator wait");

  a_standby_gate: assert property (
    (s_ff.mstby != '0) |-> ((PERI_CLK_EN & s_ff.mstby) == '0)
  ) else $error("standby module still clocked");

  c_enter_subsleep: cover property (
    (MODE == pmc_pkg::M_SACT) ##1 (MODE == pmc_pkg::M_SSLP)
  );
  c_dt_to_sub: cover property (
    (MODE == pmc_pkg::M_DTSW) ##1 (DT_EXC_START && MODE == pmc_pkg::M_SACT)
  );
  c_osc_wait_done: cover property (
    (MODE == pmc_pkg::M_OSCW) ##1 (MODE == pmc_pkg::M_ACT)
  );

endmodule : pmc_top

// file: dv/pmc_cpu_model.sv
// CPU core stand-in: turns a bench toggle into a SLEEP pulse, counts exception starts.
// Assumes the controller samples SLEEP_EXEC on the same clock.
`timescale 1ns/10ps
module pmc_cpu_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Bench command and controller answers
  input  wire logic go,
  input  wire logic exc,
  input  wire logic dt_exc,
  output logic      sleep_exec,
  output int        n_exc
);
  logic go_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      go_q       <= 1'b0;
      sleep_exec <= 1'b0;
      n_exc      <= 0;
    end else begin
      go_q       <= go;
      // One pulse per toggle keeps SLEEP requests a mode change apart
      sleep_exec <= go ^ go_q;
      if (exc || dt_exc) n_exc <= n_exc + 1;
    end
  end
endmodule : pmc_cpu_model

// file: dv/power_mode_controller_tb.sv
// Self-checking bench of the power mode controller.
// Assumes an APB master, CPU model and watch clock pin around the controller.
`timescale 1ns/10ps
module power_mode_controller_tb;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, rpin = 1, wclk = 0, dten = 1;
  logic        mask = 0, go = 0, cpu_en, ta_en, prdy, perr, hold, cpu_rst, exc, dtexc, slp;
  logic        osc, ret, hiz;
  logic [3:0]  paddr = 4'h0;
  logic [31:0] pwd = 32'h0, prd;
  logic [7:0]  irq = 8'h0, ena = 8'h0, peri_en, seen, r, v, sel;
  logic [2:0]  mode, last;
  logic [2:0]  mq[$];
  logic [32:0] rq[$];
  int          n_errors = 0, cmp_count = 0, nexc, nc, nt, n;
  always #25 clk = ~clk;
  // Unrelated to the system clock in period and phase
  always #85 wclk = ~wclk;
  pmc_top #(.WAIT_UNIT(2)) i_dut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .RESET_PIN_N(rpin), .WATCH_CLK(wclk), .SLEEP_EXEC(slp), .CCR_I_MASK(mask),
    .IRQ_REQ(irq), .IRQ_ENA(ena), .DT_IRQ_ENA(dten), .CPU_CLK_EN(cpu_en),
    .PERI_CLK_EN(peri_en), .TIMER_A_CLK_EN(ta_en), .OSC_ENABLE(osc), .CPU_RESET(cpu_rst),
    .CPU_RETAIN(ret), .IO_HOLD(hold), .IO_HIZ(hiz), .EXC_START(exc), .DT_EXC_START(dtexc),
    .MODE(mode));
  pmc_cpu_model i_cpu (.clk(clk), .rst(rst), .go(go), .exc(exc), .dt_exc(dtexc),
    .sleep_exec(slp), .n_exc(nexc));
  task automatic tally_and_finish(input bit timed_out);
    if (timed_out) n_errors++;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [32:0] seen_v, input logic [32:0] exp);
    cmp_count++;
    if (seen_v !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen_v);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel  <= 1'b1;
    pwr   <= w;
    paddr <= a;
    pwd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    if (i == 20) tally_and_finish(1'b1);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic rd(input logic [3:0] a, input logic [32:0] exp);
    rq.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_mode(input logic [2:0] m);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (mode === m) break;
    end
    if (i == 3000) tally_and_finish(1'b1);
  endtask : wait_mode
  // Monitor: every mode change and read answer must match the oldest note
  always @(posedge clk) begin
    if (rst) last <= 3'h0;
    else if (mode !== last) begin
      chk("mode", {30'h0, mode}, mq.size() != 0 ? {30'h0, mq.pop_front()} : 33'hX);
      last <= mode;
    end
    if (prdy === 1'b1 && !pwr) chk("rdata", {perr, prd}, rq.size() != 0 ? rq.pop_front() : 33'hX);
  end
  initial begin
    void'($urandom(82788));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(4'hC, {1'b0, 32'h20});
    rd(4'h2, {1'b1, 32'h0});
    r = 8'($urandom);
    sel = 8'h01 << r[2:0];
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'h00 : r;
      apb(1'b1, 4'h8, {24'h0, v});
      seen = 8'h0;
      repeat (2) @(posedge clk);
      repeat (16) begin
        @(posedge clk);
        seen |= peri_en;
      end
      chk("peri_clk", {25'h0, seen}, {25'h0, ~v});
    end
    apb(1'b1, 4'h4, 32'h08);
    irq <= sel;
    mq.push_back(3'h2);
    go <= ~go;
    wait_mode(3'h2);
    nc = 0;
    nt = 0;
    for (int i = 0; i < 80; i++) begin
      @(posedge clk);
      if (i == 40) begin
        mask <= 1'b1;
        ena  <= sel;
      end
      nc += cpu_en;
      nt += ta_en;
    end
    chk("cpu_clk", nc, 0);
    chk("timer_a", nt != 0, 1);
    chk("io_hold", hold, 1);
    chk("stay", mode, 3'h2);
    mq.push_back(3'h4);
    mask <= 1'b0;
    wait_mode(3'h4);
    irq <= 8'h00;
    apb(1'b1, 4'h0, 32'h30);
    apb(1'b1, 4'h4, 32'h10);
    mq.push_back(3'h5);
    mq.push_back(3'h6);
    mq.push_back(3'h0);
    go <= ~go;
    wait_mode(3'h6);
    // Wait phase is WAIT_UNIT << 3 system ticks at divider 0
    for (n = 1; n < 100; n++) begin
      @(posedge clk);
      if (mode !== 3'h6) break;
    end
    // Plus one cycle for the stopped system divider to restart
    chk("osc_wait", n, (2 << 3) + 1);
    @(posedge clk);
    chk("exc_count", nexc, 2);
    // Direct transition with its interrupt disabled falls back to sleep
    dten <= 1'b0;
    mq.push_back(3'h1);
    go <= ~go;
    wait_mode(3'h1);
    chk("sleep_osc", osc, 1);
    dten <= 1'b1;
    irq  <= sel;
    mq.push_back(3'h0);
    wait_mode(3'h0);
    irq <= 8'h00;
    // Active to subactive, new divider of two watch edges
    apb(1'b1, 4'h4, 32'h1A);
    mq.push_back(3'h5);
    mq.push_back(3'h4);
    go <= ~go;
    wait_mode(3'h4);
    repeat (40) @(posedge clk);
    nc = 0;
    nt = 0;
    repeat (200) begin
      @(posedge clk);
      nc += cpu_en;
      nt += ta_en;
    end
    chk("sub_clk", (nt >= 2 * nc - 2) && (nt <= 2 * nc + 2), 1);
    // Masked direct transition: only the reset pin may leave
    mask <= 1'b1;
    mq.push_back(3'h2);
    go <= ~go;
    wait_mode(3'h2);
    mask <= 1'b0;
    irq  <= sel;
    repeat (20) @(posedge clk);
    chk("no_wake", mode, 3'h2);
    chk("retain", ret, 1);
    rd(4'hC, {1'b0, 32'h12});
    irq <= 8'h00;
    mq.push_back(3'h7);
    mq.push_back(3'h0);
    rpin <= 1'b0;
    wait_mode(3'h7);
    chk("cpu_reset", cpu_rst, 1);
    chk("rst_osc", osc, 1);
    rpin <= 1'b1;
    wait_mode(3'h0);
    // Standby: ports released, oscillator off, wake through the wait
    apb(1'b1, 4'h0, 32'h80);
    mq.push_back(3'h3);
    go <= ~go;
    wait_mode(3'h3);
    chk("io_hiz", hiz, 1);
    chk("stby_osc", osc, 0);
    irq <= sel;
    mq.push_back(3'h6);
    mq.push_back(3'h0);
    wait_mode(3'h0);
    irq <= 8'h00;
    @(posedge clk);
    chk("exc_total", nexc, 5);
    tally_and_finish(1'b0);
  end
endmodule : power_mode_controller_tb
